// file: gpio_pin_pkg.sv
package gpio_pin_pkg;

  // ****************************************************************
  // Pin groups and controller mapping
  // ****************************************************************
  localparam int NUM_PINS    = 32;
  localparam int LP_N        = 25;
  localparam int MS_N        = 4;
  localparam int AO_N        = 3;
  localparam int MS_BASE     = 25;
  localparam int AO_BASE     = 29;
  localparam int CTRL_N      = 3;
  localparam int CTRL_W      = 32;
  localparam int FUNC_N      = 8;
  localparam int LP_CTRL0_N  = 16;
  localparam int LP_HI_CTRL  = 1;
  localparam int LP_HI_BIT0  = 0;
  localparam int MS_CTRL     = 2;
  localparam int MS_BIT0     = 15;
  localparam int AO_CTRL     = 1;
  localparam int AO_BIT0     = 29;

  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int LP_FSEL_STRIDE   = 4;
  localparam int LP_FSEL_PER_WORD = 8;
  localparam int AO_FSEL_STRIDE   = 4;
  localparam int MS_PULL_DIS_LSB  = 4;
  localparam int MS_PULL_TYPE_LSB = 0;
  localparam int WAKE_RADIO_BIT   = 0;
  localparam logic [2:0] FSEL_GPIO          = 3'h0;
  localparam logic [1:0] WAKE_FUNCTION_VALUE = 2'h1;
  localparam logic [1:0] AO0_FSEL_RST       = 2'h1;
  localparam logic [3:0] MS_MODE_RST        = 4'hF;
  localparam logic [7:0] MS_PULL_RST        = 8'hF0;
  localparam logic [NUM_PINS-1:0] PAD_PULL_UP_RST = 32'hE1FFFFFF;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [4:0] {
    SEL_OUT_VALUE    = 5'h00,
    SEL_OE_SET       = 5'h01,
    SEL_OE_CLR       = 5'h02,
    SEL_IEN_SET      = 5'h03,
    SEL_IEN_CLR      = 5'h04,
    SEL_ITYPE_SET    = 5'h05,
    SEL_ITYPE_CLR    = 5'h06,
    SEL_IPOL_SET     = 5'h07,
    SEL_IPOL_CLR     = 5'h08,
    SEL_ISTAT_CLR    = 5'h09,
    SEL_LP_FSEL      = 5'h0A,
    SEL_INVERT       = 5'h0B,
    SEL_PULL_DIS     = 5'h0C,
    SEL_PULL_TYPE    = 5'h0D,
    SEL_MS_PULL      = 5'h0E,
    SEL_MS_MODE      = 5'h0F,
    SEL_AO_FSEL      = 5'h10,
    SEL_AO_PULL_DIS  = 5'h11,
    SEL_WAKE_CTRL    = 5'h12
  } reg_sel_e;

  typedef struct packed {
    logic              valid;
    reg_sel_e          sel;
    logic [1:0]        idx;
    logic [CTRL_W-1:0] data;
  } reg_cmd_s;

  typedef struct packed {
    logic [NUM_PINS-1:0] out;
    logic [NUM_PINS-1:0] oe;
    logic [NUM_PINS-1:0] pull_up;
    logic [NUM_PINS-1:0] pull_down;
  } pad_s;

  typedef struct packed {
    logic [NUM_PINS-1:0]            s1;
    logic [NUM_PINS-1:0]            s2;
    logic [NUM_PINS-1:0]            s3;
    logic [CTRL_N-1:0][CTRL_W-1:0]  out_val;
    logic [CTRL_N-1:0][CTRL_W-1:0]  oe;
    logic [CTRL_N-1:0][CTRL_W-1:0]  ien;
    logic [CTRL_N-1:0][CTRL_W-1:0]  ipol;
    logic [CTRL_N-1:0][CTRL_W-1:0]  itype;
    logic [CTRL_N-1:0][CTRL_W-1:0]  istat;
    logic [CTRL_N-1:0][CTRL_W-1:0]  in_data;
    logic [LP_N-1:0][2:0]           lp_fsel;
    logic [AO_N-1:0][1:0]           ao_fsel;
    logic [LP_N-1:0]                invert;
    logic [LP_N-1:0]                pull_dis;
    logic [LP_N-1:0]                pull_type;
    logic [7:0]                     ms_pull;
    logic [MS_N-1:0]                ms_analog;
    logic [AO_N-1:0]                ao_pull_dis;
    logic                           radio_en;
    pad_s                           pad;
    logic [NUM_PINS-1:0]            periph_in;
    logic [CTRL_N-1:0]              int_req;
    logic                           cpu_wake;
    logic                           radio_wake;
  } state_s;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [1:0] pin_ctrl(input int i);
    if (i < LP_CTRL0_N) begin
      return 2'h0;
    end else if (i < MS_BASE) begin
      return 2'(LP_HI_CTRL);
    end else if (i < AO_BASE) begin
      return 2'(MS_CTRL);
    end
    return 2'(AO_CTRL);
  endfunction : pin_ctrl

  function automatic logic [4:0] pin_bit(input int i);
    if (i < LP_CTRL0_N) begin
      return 5'(i);
    end else if (i < MS_BASE) begin
      return 5'(i - LP_CTRL0_N + LP_HI_BIT0);
    end else if (i < AO_BASE) begin
      return 5'(i - MS_BASE + MS_BIT0);
    end
    return 5'(i - AO_BASE + AO_BIT0);
  endfunction : pin_bit

  function automatic logic [CTRL_W-1:0] set_clr(input logic [CTRL_W-1:0] cur, input logic set,
                                                input logic [CTRL_W-1:0] d);
    return set ? (cur | d) : (cur & ~d);
  endfunction : set_clr

  // {enable, polarity, type}: level when type 0, edge when type 1
  function automatic logic int_hit(input logic en, input logic pol, input logic typ,
                                   input logic lvl, input logic prev);
    logic want;
    want = pol ? lvl : ~lvl;
    if (!en) begin
      return 1'b0;
    end else if (!typ) begin
      return want;
    end
    return want & (lvl ^ prev);
  endfunction : int_hit

endpackage : gpio_pin_pkg

// file: gpio_pin_config_wake_irq.sv
`timescale 1ns/1ns
module gpio_pin_config_wake_irq
  import gpio_pin_pkg::*;
(
  // Clock and reset
  input  wire logic                                  clk_i,
  input  wire logic                                  nrst_i,
  // Register write command
  input  wire reg_cmd_s                              cmd_i,
  // Pads
  input  wire logic [NUM_PINS-1:0]                   pad_i,
  output pad_s                                       pad_o,
  output logic [MS_N-1:0]                            analog_en_o,
  // Peripherals
  input  wire logic [NUM_PINS-1:0][FUNC_N-1:0]       periph_out_i,
  input  wire logic [NUM_PINS-1:0][FUNC_N-1:0]       periph_oe_i,
  output logic [NUM_PINS-1:0]                        periph_in_o,
  // Status
  output logic [CTRL_N-1:0][CTRL_W-1:0]              in_data_o,
  output logic [CTRL_N-1:0][CTRL_W-1:0]              int_status_o,
  output logic [CTRL_N-1:0]                          int_o,
  output logic                                       cpu_wake_o,
  output logic                                       radio_wake_o
);

  state_s r_reg;
  state_s r_next;

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    logic [CTRL_N-1:0][CTRL_W-1:0] lvl;
    logic [CTRL_N-1:0][CTRL_W-1:0] prv;
    logic [1:0]                    c;
    logic [4:0]                    b;
    logic [2:0]                    fsel;
    logic                          ctl_ok;
    logic                          own;
    logic                          wake_pin;
    logic                          analog;
    logic                          pdis;
    logic                          ptyp;
    logic                          rise;
    logic                          inv;
    int                            p;
    lvl      = '0;
    prv      = '0;
    c        = 2'h0;
    b        = 5'h00;
    fsel     = FSEL_GPIO;
    own      = 1'b1;
    wake_pin = 1'b0;
    analog   = 1'b0;
    pdis     = 1'b0;
    ptyp     = 1'b0;
    rise     = 1'b0;
    inv      = 1'b0;
    p        = 0;
    ctl_ok   = int'(cmd_i.idx) < CTRL_N;
    r_next   = r_reg;

    // Two-stage pad synchroniser plus one history stage for edges
    r_next.s1 = pad_i;
    r_next.s2 = r_reg.s1;
    r_next.s3 = r_reg.s2;

    // Software writes
    if (cmd_i.valid) begin
      case (cmd_i.sel)
        SEL_OUT_VALUE: begin
          if (ctl_ok) r_next.out_val[cmd_i.idx] = cmd_i.data;
        end
        SEL_OE_SET, SEL_OE_CLR: begin
          if (ctl_ok) r_next.oe[cmd_i.idx] = set_clr(r_reg.oe[cmd_i.idx], cmd_i.sel == SEL_OE_SET,
                                                     cmd_i.data);
        end
        SEL_IEN_SET, SEL_IEN_CLR: begin
          if (ctl_ok) r_next.ien[cmd_i.idx] = set_clr(r_reg.ien[cmd_i.idx], cmd_i.sel == SEL_IEN_SET,
                                                      cmd_i.data);
        end
        SEL_ITYPE_SET, SEL_ITYPE_CLR: begin
          if (ctl_ok) r_next.itype[cmd_i.idx] = set_clr(r_reg.itype[cmd_i.idx],
                                                        cmd_i.sel == SEL_ITYPE_SET, cmd_i.data);
        end
        SEL_IPOL_SET, SEL_IPOL_CLR: begin
          if (ctl_ok) r_next.ipol[cmd_i.idx] = set_clr(r_reg.ipol[cmd_i.idx],
                                                       cmd_i.sel == SEL_IPOL_SET, cmd_i.data);
        end
        SEL_ISTAT_CLR: begin
          if (ctl_ok) r_next.istat[cmd_i.idx] = r_reg.istat[cmd_i.idx] & ~cmd_i.data;
        end
        SEL_LP_FSEL: begin
          for (int k = 0; k < LP_FSEL_PER_WORD; k++) begin
            p = int'(cmd_i.idx) * LP_FSEL_PER_WORD + k;
            if (p < LP_N) r_next.lp_fsel[p] = cmd_i.data[k*LP_FSEL_STRIDE +: 3];
          end
        end
        SEL_INVERT: begin
          r_next.invert = cmd_i.data[LP_N-1:0];
        end
        SEL_PULL_DIS: begin
          r_next.pull_dis = cmd_i.data[LP_N-1:0];
        end
        SEL_PULL_TYPE: begin
          r_next.pull_type = cmd_i.data[LP_N-1:0];
        end
        SEL_MS_PULL: begin
          r_next.ms_pull = cmd_i.data[7:0];
        end
        SEL_MS_MODE: begin
          r_next.ms_analog = cmd_i.data[MS_N-1:0];
        end
        SEL_AO_FSEL: begin
          for (int k = 0; k < AO_N; k++) begin
            r_next.ao_fsel[k] = cmd_i.data[k*AO_FSEL_STRIDE +: 2];
          end
        end
        SEL_AO_PULL_DIS: begin
          r_next.ao_pull_dis = cmd_i.data[AO_N-1:0];
        end
        SEL_WAKE_CTRL: begin
          r_next.radio_en = cmd_i.data[WAKE_RADIO_BIT];
        end
        default: begin
        end
      endcase
    end

    // Pads, pulls and controller input data
    r_next.in_data = '0;
    for (int i = 0; i < NUM_PINS; i++) begin
      c        = pin_ctrl(i);
      b        = pin_bit(i);
      lvl[c][b] = r_reg.s2[i];
      prv[c][b] = r_reg.s3[i];
      fsel     = FSEL_GPIO;
      wake_pin = 1'b0;
      analog   = 1'b0;
      inv      = 1'b0;
      if (i < LP_N) begin
        fsel = r_reg.lp_fsel[i];
        inv  = r_reg.invert[i];
        pdis = r_reg.pull_dis[i];
        ptyp = r_reg.pull_type[i];
      end else if (i < AO_BASE) begin
        analog = r_reg.ms_analog[i-MS_BASE];
        pdis   = r_reg.ms_pull[MS_PULL_DIS_LSB + i - MS_BASE];
        ptyp   = r_reg.ms_pull[MS_PULL_TYPE_LSB + i - MS_BASE];
      end else begin
        fsel     = {1'b0, r_reg.ao_fsel[i-AO_BASE]};
        wake_pin = r_reg.ao_fsel[i-AO_BASE] == WAKE_FUNCTION_VALUE;
        pdis     = r_reg.ao_pull_dis[i-AO_BASE];
        ptyp     = 1'b0;
      end
      // A wake-selected always-on pin stays an input owned by the controller
      own = (fsel == FSEL_GPIO) || wake_pin;
      if (!own) begin
        r_next.pad.out[i] = periph_out_i[i][fsel];
        r_next.pad.oe[i]  = periph_oe_i[i][fsel];
      end else if (wake_pin) begin
        r_next.pad.out[i] = 1'b0;
        r_next.pad.oe[i]  = 1'b0;
      end else begin
        r_next.pad.out[i] = r_reg.out_val[c][b] ^ inv;
        r_next.pad.oe[i]  = r_reg.oe[c][b] & ~analog;
      end
      // One pull circuit, same encoding in both directions
      r_next.pad.pull_up[i]   = ~pdis & ~ptyp;
      r_next.pad.pull_down[i] = ~pdis & ptyp;
      r_next.periph_in[i]     = own ? 1'b0 : r_reg.s2[i];
      r_next.in_data[c][b]    = (own && !analog) ? r_reg.s2[i] : 1'b0;
      if (wake_pin && r_reg.s2[i] && !r_reg.s3[i]) begin
        rise = 1'b1;
      end
    end

    // Interrupt sensing: set wins over a same-cycle clear
    for (int q = 0; q < CTRL_N; q++) begin
      for (int j = 0; j < CTRL_W; j++) begin
        if (int_hit(r_reg.ien[q][j], r_reg.ipol[q][j], r_reg.itype[q][j], lvl[q][j], prv[q][j])) begin
          r_next.istat[q][j] = 1'b1;
        end
      end
      r_next.int_req[q] = |r_next.istat[q];
    end

    r_next.cpu_wake   = rise;
    r_next.radio_wake = rise & r_reg.radio_en;
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      r_reg             <= '0;
      r_reg.pad.pull_up <= PAD_PULL_UP_RST;
      // Synchronisers start at the pulled idle level: no false edge after reset
      r_reg.s1          <= PAD_PULL_UP_RST;
      r_reg.s2          <= PAD_PULL_UP_RST;
      r_reg.s3          <= PAD_PULL_UP_RST;
      r_reg.ao_fsel[0]  <= AO0_FSEL_RST;
      r_reg.ms_analog   <= MS_MODE_RST;
      r_reg.ms_pull     <= MS_PULL_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign pad_o        = r_reg.pad;
  assign analog_en_o  = r_reg.ms_analog;
  assign periph_in_o  = r_reg.periph_in;
  assign in_data_o    = r_reg.in_data;
  assign int_status_o = r_reg.istat;
  assign int_o        = r_reg.int_req;
  assign cpu_wake_o   = r_reg.cpu_wake;
  assign radio_wake_o = r_reg.radio_wake;

endmodule : gpio_pin_config_wake_irq

// file: gpio_pin_props.sv
`timescale 1ns/1ns
module gpio_pin_props
  import gpio_pin_pkg::*;
(
  // Clock and inputs
  input wire logic                          clk_i,
  input wire logic                          nrst_i,
  input wire reg_cmd_s                      cmd_i,
  input wire logic [NUM_PINS-1:0]           pad_i,
  // Outputs
  input wire pad_s                          pad_o,
  input wire logic [MS_N-1:0]               analog_en_o,
  input wire logic [CTRL_N-1:0][CTRL_W-1:0] in_data_o,
  input wire logic [CTRL_N-1:0][CTRL_W-1:0] int_status_o,
  input wire logic                          cpu_wake_o,
  input wire logic                          radio_wake_o
);
  // ****************************************************************
  // Checks
  // ****************************************************************
  logic [2:0] up_reg;
  // Synchronisers settle before pad history is trusted
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      up_reg <= 3'h0;
    end else if (up_reg != 3'h7) begin
      up_reg <= up_reg + 3'h1;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  rst_state_a: assert property ($rose(nrst_i) |-> pad_o.oe == '0 && pad_o.pull_up == 32'hE1FFFFFF
    && analog_en_o == 4'hF && int_status_o == '0) else $error("bad state after reset");
  pull_excl_a: assert property ((pad_o.pull_up & pad_o.pull_down) == '0
    && pad_o.pull_down[31:29] == 3'h0) else $error("bad pull combination");
  oe_cause_a: assert property ($rose(pad_o.oe[18]) |-> $past(cmd_i.valid, 2) && $past(cmd_i.sel, 2) == SEL_OE_SET
    && $past(cmd_i.idx, 2) == 2'h1 && $past(cmd_i.data[2], 2)) else $error("pin 18 drive without enable set");
  wake_lat_a: assert property (cpu_wake_o && up_reg == 3'h7 |->
    ($past(pad_i[31:29], 3) & ~$past(pad_i[31:29], 4)) != 3'h0) else $error("wake not three cycles after rise");
  wake_pair_a: assert property (radio_wake_o |-> cpu_wake_o) else $error("radio wake alone");
  wake_pulse_a: assert property (cpu_wake_o |=> !cpu_wake_o) else $error("wake pulse too long");
  istat_clr_a: assert property ((|($past(int_status_o[0]) & ~int_status_o[0])) |->
    $past(cmd_i.valid) && $past(cmd_i.sel) == SEL_ISTAT_CLR && $past(cmd_i.idx) == 2'h0) else $error("status lost");
  analog_in_a: assert property (analog_en_o[0] && $past(analog_en_o[0]) |->
    in_data_o[2][15] == 1'b0) else $error("analog pin read as digital");
endmodule : gpio_pin_props

bind gpio_pin_config_wake_irq gpio_pin_props u_props (.clk_i, .nrst_i, .cmd_i, .pad_i, .pad_o, .analog_en_o,
  .in_data_o, .int_status_o, .cpu_wake_o, .radio_wake_o);

// file: pad_world.sv
`timescale 1ns/1ns
module pad_world
  import gpio_pin_pkg::*;
(
  // Clock
  input  wire logic                clk_i,
  // Device pads and outside drive
  input  wire pad_s                pad_o,
  input  wire logic [NUM_PINS-1:0] ext_en_i,
  input  wire logic [NUM_PINS-1:0] ext_val_i,
  output logic      [NUM_PINS-1:0] level_o
);
  // ****************************************************************
  // Pad resolution
  // ****************************************************************
  logic tog_reg = 1'b0;
  always_ff @(posedge clk_i) begin
    tog_reg <= ~tog_reg;
  end
  // Floating pad wanders every cycle
  always_comb begin
    for (int i = 0; i < NUM_PINS; i++) begin
      level_o[i] = pad_o.oe[i] ? pad_o.out[i] : ext_en_i[i] ? ext_val_i[i] :
                   pad_o.pull_up[i] ? 1'b1 : pad_o.pull_down[i] ? 1'b0 : tog_reg;
    end
  end
endmodule : pad_world

// file: tb.sv
`timescale 1ns/1ns
module tb
  import gpio_pin_pkg::*;
;
  logic                            clk_i = 1'b0;
  logic                            nrst_i = 1'b0;
  reg_cmd_s                        cmd_i = '0;
  logic [NUM_PINS-1:0][FUNC_N-1:0] p_out = '0;
  logic [NUM_PINS-1:0][FUNC_N-1:0] p_oe = '0;
  logic [NUM_PINS-1:0]             ext_en = '0;
  logic [NUM_PINS-1:0]             ext_val = '0;
  logic [NUM_PINS-1:0]             lvl;
  logic [NUM_PINS-1:0]             p_in;
  pad_s                            pad_o;
  logic [MS_N-1:0]                 analog_en_o;
  logic [CTRL_N-1:0][CTRL_W-1:0]   in_data_o;
  logic [CTRL_N-1:0][CTRL_W-1:0]   int_status_o;
  logic [CTRL_N-1:0]               int_o;
  logic                            cpu_wake_o;
  logic                            radio_wake_o;
  int                              num_errors = 0;
  int                              n_tests = 0;

  always #2 clk_i = ~clk_i;

  gpio_pin_config_wake_irq DUT (.clk_i(clk_i), .nrst_i(nrst_i), .cmd_i(cmd_i), .pad_i(lvl), .pad_o(pad_o),
    .analog_en_o(analog_en_o), .periph_out_i(p_out), .periph_oe_i(p_oe), .periph_in_o(p_in),
    .in_data_o(in_data_o), .int_status_o(int_status_o), .int_o(int_o), .cpu_wake_o(cpu_wake_o),
    .radio_wake_o(radio_wake_o));
  pad_world u_world (.clk_i(clk_i), .pad_o(pad_o), .ext_en_i(ext_en), .ext_val_i(ext_val), .level_o(lvl));

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic ticks(input int n);
    repeat (n) @(negedge clk_i);
  endtask : ticks
  task automatic wr(input reg_sel_e s, input logic [1:0] i, input logic [31:0] d);
    cmd_i = '{1'b1, s, i, d};
    @(negedge clk_i);
    cmd_i.valid = 1'b0;
    @(negedge clk_i);
  endtask : wr
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : wrap_up
  task automatic wake(input logic radio);
    int k;
    k = 0;
    while (cpu_wake_o !== 1'b1 && k < 8) begin
      ticks(1);
      k++;
    end
    if (cpu_wake_o !== 1'b1) begin
      num_errors++;
      wrap_up();
    end
    chk("radio wake", 32'(radio_wake_o), 32'(radio));
  endtask : wake

  initial begin
    #100000;
    num_errors++;
    wrap_up();
  end

  // ****************************************************************
  // Sequence
  // ****************************************************************
  initial begin
    ticks(2);
    nrst_i = 1'b1;
    chk("oe", pad_o.oe, 32'h0);
    chk("pull up", pad_o.pull_up, 32'hE1FFFFFF);
    chk("analog", 32'(analog_en_o), 32'hF);
    chk("status", int_status_o[0], 32'h0);
    wr(SEL_OE_SET, 2'h3, 32'hFFFFFFFF);
    chk("idx 3 oe", pad_o.oe, 32'h0);
    wr(SEL_OUT_VALUE, 2'h1, 32'h4);
    wr(SEL_OE_SET, 2'h1, 32'h4);
    chk("oe 18", 32'(pad_o.oe[18]), 32'h1);
    chk("out 18", 32'(pad_o.out[18]), 32'h1);
    wr(SEL_INVERT, 2'h0, 32'h40000);
    chk("inv 18", 32'(pad_o.out[18]), 32'h0);
    wr(SEL_OE_CLR, 2'h1, 32'h4);
    ext_en[18] = 1'b1;
    for (int v = 1; v >= 0; v--) begin
      ext_val[18] = 1'(v);
      ticks(4);
      chk("in 18", 32'(in_data_o[1][2]), 32'(v));
    end
    for (int c = 0; c < 8; c++) begin
      wr(c[2] ? SEL_OE_SET : SEL_OE_CLR, 2'h0, 32'h8);
      wr(SEL_PULL_DIS, 2'h0, 32'(c[1]) << 3);
      wr(SEL_PULL_TYPE, 2'h0, 32'(c[0]) << 3);
      chk("up 3", 32'(pad_o.pull_up[3]), 32'(!c[1] && !c[0]));
      chk("down 3", 32'(pad_o.pull_down[3]), 32'(!c[1] && c[0]));
    end
    wr(SEL_MS_MODE, 2'h0, 32'h0);
    chk("analog off", 32'(analog_en_o), 32'h0);
    wr(SEL_MS_PULL, 2'h0, 32'h1);
    chk("ms1 down", 32'(pad_o.pull_down[25]), 32'h1);
    wr(SEL_OUT_VALUE, 2'h2, 32'h8000);
    wr(SEL_OE_SET, 2'h2, 32'h8000);
    chk("ms1 drive", 32'({pad_o.oe[25], pad_o.out[25]}), 32'h3);
    wr(SEL_OE_SET, 2'h1, 32'h40000000);
    chk("ao1 oe", 32'(pad_o.oe[30]), 32'h1);
    wr(SEL_AO_PULL_DIS, 2'h0, 32'h2);
    chk("ao up", 32'(pad_o.pull_up[31:29]), 32'h5);
    p_out[0][3] = 1'b1;
    p_oe[0][3] = 1'b1;
    p_out[31][2] = 1'b1;
    p_oe[31][2] = 1'b1;
    wr(SEL_LP_FSEL, 2'h0, 32'h3);
    chk("pin0 periph", 32'({pad_o.oe[0], pad_o.out[0]}), 32'h3);
    ticks(3);
    chk("pin0 in", 32'(p_in[0]), 32'h1);
    wr(SEL_LP_FSEL, 2'h0, 32'h0);
    chk("pin0 gpio", 32'(pad_o.oe[0]), 32'h0);
    chk("pin0 in gpio", 32'(p_in[0]), 32'h0);
    wr(SEL_AO_FSEL, 2'h0, 32'h201);
    chk("ao2 periph", 32'({pad_o.oe[31], pad_o.out[31]}), 32'h3);
    ext_en[5] = 1'b1;
    ext_val[5] = 1'b1;
    ticks(4);
    wr(SEL_IEN_SET, 2'h0, 32'h20);
    for (int t = 0; t < 4; t++) begin
      ext_val[5] = ~t[1];
      ticks(4);
      wr(t[1] ? SEL_IPOL_SET : SEL_IPOL_CLR, 2'h0, 32'h20);
      wr(t[0] ? SEL_ITYPE_SET : SEL_ITYPE_CLR, 2'h0, 32'h20);
      wr(SEL_ISTAT_CLR, 2'h0, 32'h20);
      ext_val[5] = t[1];
      ticks(2);
      chk("stat early", int_status_o[0], 32'h0);
      ticks(1);
      chk("stat", int_status_o[0], 32'h20);
      chk("int", 32'(int_o), 32'h1);
      ext_val[5] = ~t[1];
      ticks(4);
      wr(SEL_ISTAT_CLR, 2'h0, 32'h20);
      chk("stat clr", int_status_o[0], 32'h0);
    end
    wr(SEL_IEN_CLR, 2'h0, 32'h20);
    ext_val[5] = 1'b1;
    ticks(4);
    chk("masked", int_status_o[0], 32'h0);
    ext_en[29] = 1'b1;
    ext_val[29] = 1'b0;
    ticks(5);
    ext_val[29] = 1'b1;
    wake(1'b0);
    wr(SEL_WAKE_CTRL, 2'h0, 32'h1);
    ext_val[29] = 1'b0;
    ticks(5);
    ext_val[29] = 1'b1;
    wake(1'b1);
    nrst_i = 1'b0;
    ticks(2);
    nrst_i = 1'b1;
    chk("oe again", pad_o.oe, 32'h0);
    chk("pull up again", pad_o.pull_up, 32'hE1FFFFFF);
    ext_val[29] = 1'b0;
    ticks(5);
    ext_val[29] = 1'b1;
    wake(1'b0);
    wrap_up();
  end
endmodule : tb
